// File: inc/dsh_pkg.sv
package dsh_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS     = 10;
    localparam int WAIT_NORMAL_US    = 2;
    localparam int WAIT_SUSPEND_US   = 1000;
    localparam int WAIT_NORMAL_CYC   = (WAIT_NORMAL_US * 1000
                                        + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_SUSPEND_CYC  = (WAIT_SUSPEND_US * 1000
                                        + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCK_HALF_CYC      = 5;   // 10 MHz max serial clock

    // ==========================================================
    // Frame layout
    localparam logic       DIR_WRITE     = 1'b0;
    localparam logic       DIR_READ      = 1'b1;
    localparam logic [6:0] ACCEL_ID_ADDR = 7'h00;
    localparam logic [6:0] ACCEL_DATA_ADDR = 7'h12;
    localparam logic [3:0] ACCEL_DATA_BYTES = 4'h7;
    localparam logic [3:0] BYTE_BITS     = 4'h8;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_INIT  = 3'b001,
        ST_IDLE  = 3'b010,
        ST_XFER  = 3'b011,
        ST_GAP   = 3'b100
    } dsh_state_t;

    typedef struct packed {
        logic       part_gyro;  // 1 gyro, 0 accel
        logic       dir_read;
        logic [6:0] addr;
        logic [7:0] wdata;
        logic [3:0] nbytes;     // data bytes to clock after address
        logic       suspend;
    } dsh_req_t;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } dsh_rsp_t;

endpackage : dsh_pkg

// File: hdl/dsh_shift.sv
`timescale 1ns/1ps
`default_nettype none
// ==============================================================
// SPI bit engine, mode 11, runs on the link clock
module dsh_shift
    import dsh_pkg::*;
(
    // Link clock and reset
    input  wire logic       link_clk,
    input  wire logic       link_rst,
    // Frame request, held stable while go_tgl differs from done_tgl
    input  wire logic       go_tgl,
    input  wire logic [15:0] first_word,
    input  wire logic [3:0] nbytes,
    input  wire logic       part_gyro,
    // Pins
    output logic            sck,
    output logic            mosi,
    output logic            accel_chip_select_n,
    output logic            gyro_chip_select_n,
    input  wire logic       miso_accel,
    input  wire logic       miso_gyro,
    // Results
    output logic            byte_tgl,
    output logic [7:0]      byte_data,
    output logic            done_tgl
);
    logic [2:0]  go_sync_reg;
    logic        busy_reg;
    logic        phase_reg;
    logic [7:0]  tx_reg;
    logic [7:0]  rx_reg;
    logic [2:0]  bit_reg;
    logic [4:0]  byte_reg;
    logic [4:0]  total_w;
    logic        miso_w;
    logic        start_w;

    assign total_w = {1'b0, nbytes} + 5'h01;    // Address byte first
    assign miso_w  = part_gyro ? miso_gyro : miso_accel;
    assign start_w = (go_sync_reg[2] != go_sync_reg[1]) && !busy_reg;

    // ==========================================================
    // Clock idles high so the device sees mode 11 at select fall
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            go_sync_reg <= 3'h0;
            busy_reg <= 1'b0;
            phase_reg <= 1'b0;
            tx_reg <= 8'h00;
            rx_reg <= 8'h00;
            bit_reg <= 3'h0;
            byte_reg <= 5'h00;
            sck <= 1'b1;
            mosi <= 1'b1;
            accel_chip_select_n <= 1'b1;
            gyro_chip_select_n <= 1'b1;
            byte_tgl <= 1'b0;
            byte_data <= 8'h00;
            done_tgl <= 1'b0;
        end else begin
            go_sync_reg <= {go_sync_reg[1:0], go_tgl};
            if (start_w) begin
                busy_reg <= 1'b1;
                accel_chip_select_n <= part_gyro;
                gyro_chip_select_n <= !part_gyro;
                tx_reg <= first_word[15:8];
                mosi <= first_word[15];
                bit_reg <= 3'h0;
                byte_reg <= 5'h00;
                phase_reg <= 1'b0;
            end else if (busy_reg && byte_reg == total_w) begin
                accel_chip_select_n <= 1'b1;
                gyro_chip_select_n <= 1'b1;
                busy_reg <= 1'b0;
                done_tgl <= !done_tgl;
            end else if (busy_reg && !phase_reg) begin
                sck <= 1'b0;                        // drive on fall
                mosi <= tx_reg[7];
                phase_reg <= 1'b1;
            end else if (busy_reg) begin
                sck <= 1'b1;                        // sample on rise
                rx_reg <= {rx_reg[6:0], miso_w};
                tx_reg <= {tx_reg[6:0], 1'b1};
                phase_reg <= 1'b0;
                bit_reg <= bit_reg + 3'h1;
                if (bit_reg == 3'h7) begin
                    byte_reg <= byte_reg + 5'h01;
                    tx_reg <= first_word[7:0];      // Write data or don't care
                    if (byte_reg != 5'h00) begin
                        byte_data <= {rx_reg[6:0], miso_w};
                        byte_tgl <= !byte_tgl;
                    end
                end
            end
        end
    end

    a_select_exclusive: assert property (@(posedge link_clk)
        disable iff (link_rst)
        !(!accel_chip_select_n && !gyro_chip_select_n))
        else $error("both chip selects low");

    a_idle_clock_high: assert property (@(posedge link_clk)
        disable iff (link_rst)
        ($fell(accel_chip_select_n) || $fell(gyro_chip_select_n)) |-> sck)
        else $error("clock low at select fall");

endmodule : dsh_shift
`default_nettype wire

// File: hdl/dsh_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==============================================================
// Host controller for the two-part sensor over SPI
module dsh_host
    import dsh_pkg::*;
(
    // System clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Link clock and reset
    input  wire logic       link_clk,
    input  wire logic       link_rst,
    // Request port
    input  wire logic       req_valid,
    input  wire dsh_req_t   req,
    output logic            req_ready,
    // Answer port
    output dsh_rsp_t        rsp,
    output logic            init_done,
    // Device pins
    output logic            protocol_select_strap,
    output logic            sck,
    output logic            mosi,
    output logic            accel_chip_select_n,
    output logic            gyro_chip_select_n,
    input  wire logic       accel_serial_out,
    input  wire logic       gyro_serial_out
);
    dsh_state_t  state_reg;
    dsh_state_t  state_next;
    dsh_req_t    cur_reg;
    logic        go_tgl_reg;
    logic [2:0]  done_sync_reg;
    logic [2:0]  byte_sync_reg;
    logic [3:0]  cnt_reg;
    logic [16:0] gap_reg;
    logic        dummy_reg;
    logic        byte_tgl_w;
    logic        done_tgl_w;
    logic [7:0]  byte_data_w;
    logic        done_w;
    logic        byte_w;
    logic        gap_end_w;
    logic [16:0] gap_load_w;
    logic        need_gap_w;

    // ==========================================================
    // Crossings: toggles pass two flops, edge taken after them
    assign done_w = done_sync_reg[2] != done_sync_reg[1];
    assign byte_w = byte_sync_reg[2] != byte_sync_reg[1];
    assign gap_end_w = gap_reg == 17'h00000;
    // The normal gap also covers the I2C one; suspend is the longer wait
    assign gap_load_w = cur_reg.suspend ? 17'(WAIT_SUSPEND_CYC)
                                        : 17'(WAIT_NORMAL_CYC);
    assign need_gap_w = cur_reg.dir_read == DIR_WRITE;

    // ==========================================================
    // Sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: state_next = ST_INIT;
            ST_INIT:  state_next = ST_XFER;
            ST_IDLE:  if (req_valid) state_next = ST_XFER;
            ST_XFER:  if (done_w) state_next = ST_GAP;
            ST_GAP:   if (gap_end_w) state_next = ST_IDLE;
            default:  state_next = ST_RESET;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_RESET;
            cur_reg <= '0;
            go_tgl_reg <= 1'b0;
            done_sync_reg <= 3'h0;
            byte_sync_reg <= 3'h0;
            cnt_reg <= 4'h0;
            gap_reg <= 17'h00000;
            dummy_reg <= 1'b0;
            req_ready <= 1'b0;
            rsp <= '0;
            init_done <= 1'b0;
            // Strap at ground keeps the bus on SPI; no I2C framing is needed
            protocol_select_strap <= 1'b0;
        end else begin
            state_reg <= state_next;
            done_sync_reg <= {done_sync_reg[1:0], done_tgl_w};
            byte_sync_reg <= {byte_sync_reg[1:0], byte_tgl_w};
            rsp.valid <= 1'b0;
            req_ready <= state_next == ST_IDLE;
            if (state_reg == ST_INIT) begin
                // Dummy accel read flips the accel port to SPI
                cur_reg <= '{part_gyro: 1'b0, dir_read: DIR_READ,
                             addr: ACCEL_ID_ADDR, wdata: 8'h00,
                             nbytes: 4'h2, suspend: 1'b0};
                dummy_reg <= 1'b1;
                go_tgl_reg <= !go_tgl_reg;
                cnt_reg <= 4'h0;
            end else if (state_reg == ST_IDLE && req_valid) begin
                cur_reg <= req;
                // Accel reads clock one extra byte for the filler it sends
                // Writes always carry exactly one data byte
                if (!req.part_gyro && req.dir_read)
                    cur_reg.nbytes <= req.nbytes + 4'h1;
                if (req.dir_read == DIR_WRITE)
                    cur_reg.nbytes <= 4'h1;
                go_tgl_reg <= !go_tgl_reg;
                cnt_reg <= 4'h0;
            end
            if (state_reg == ST_XFER && byte_w) begin
                cnt_reg <= cnt_reg + 4'h1;
                // Accel read drops its leading filler byte
                if (cur_reg.dir_read && !dummy_reg
                    && (cur_reg.part_gyro || cnt_reg != 4'h0)) begin
                    rsp.valid <= 1'b1;
                    rsp.data <= byte_data_w;
                    rsp.last <= cnt_reg + 4'h1 == cur_reg.nbytes;
                end
            end
            if (state_reg == ST_XFER && done_w) begin
                gap_reg <= need_gap_w ? gap_load_w : 17'h00000;
                if (dummy_reg) init_done <= 1'b1;
                dummy_reg <= 1'b0;
            end else if (!gap_end_w) begin
                gap_reg <= gap_reg - 17'h00001;
            end
        end
    end

    // ==========================================================
    // Link-side bit engine
    dsh_shift u_shift (
        .link_clk            (link_clk),
        .link_rst            (link_rst),
        .go_tgl              (go_tgl_reg),
        .first_word          ({cur_reg.dir_read, cur_reg.addr,
                               cur_reg.wdata}),
        .nbytes              (cur_reg.nbytes),
        .part_gyro           (cur_reg.part_gyro),
        .sck                 (sck),
        .mosi                (mosi),
        .accel_chip_select_n (accel_chip_select_n),
        .gyro_chip_select_n  (gyro_chip_select_n),
        .miso_accel          (accel_serial_out),
        .miso_gyro           (gyro_serial_out),
        .byte_tgl            (byte_tgl_w),
        .byte_data           (byte_data_w),
        .done_tgl            (done_tgl_w)
    );

    // ==========================================================
    // Checks
    sequence s_write_done;
        state_reg == ST_XFER && done_w && cur_reg.dir_read == DIR_WRITE
            && !cur_reg.suspend;
    endsequence

    a_write_gap: assert property (@(posedge clk) disable iff (rst)
        s_write_done |=> !req_ready [*8])
        else $error("request accepted inside write gap");

    a_gap_length: assert property (@(posedge clk) disable iff (rst)
        s_write_done |=> gap_reg == 17'(WAIT_NORMAL_CYC))
        else $error("write gap length wrong");

    a_strap_spi: assert property (@(posedge clk) disable iff (rst)
        !protocol_select_strap)
        else $error("strap not at SPI level");

    a_init_first: assert property (@(posedge clk) disable iff (rst)
        req_ready |-> init_done)
        else $error("ready before dummy read");

    a_ready_idle: assert property (@(posedge clk) disable iff (rst)
        $rose(req_ready) |-> state_reg == ST_IDLE)
        else $error("ready outside idle");

    a_rsp_xfer: assert property (@(posedge clk) disable iff (rst)
        rsp.valid |-> $past(state_reg) == ST_XFER)
        else $error("answer outside transfer");

    // ==========================================================
    // Request taking and answer filtering
    sequence s_take;
        state_reg == ST_IDLE && req_valid;
    endsequence

    sequence s_filler_byte;
        state_reg == ST_XFER && byte_w && cur_reg.dir_read
            && !cur_reg.part_gyro && cnt_reg == 4'h0;
    endsequence

    sequence s_write_byte;
        state_reg == ST_XFER && byte_w && cur_reg.dir_read == DIR_WRITE;
    endsequence

    a_take_once: assert property (@(posedge clk) disable iff (rst)
        s_take |=> !req_ready)
        else $error("ready held after take");

    a_take_xfer: assert property (@(posedge clk) disable iff (rst)
        s_take |=> state_reg == ST_XFER)
        else $error("taken request not started");

    a_filler_dropped: assert property (@(posedge clk) disable iff (rst)
        s_filler_byte |=> !rsp.valid)
        else $error("accel filler byte passed on");

    a_write_silent: assert property (@(posedge clk) disable iff (rst)
        s_write_byte |=> !rsp.valid)
        else $error("answer during write");

    a_init_sticky: assert property (@(posedge clk) disable iff (rst)
        init_done |=> init_done)
        else $error("init flag dropped");

    a_gap_not_ready: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_GAP |-> !req_ready)
        else $error("ready inside gap");

endmodule : dsh_host
`default_nettype wire

// File: testbench/dsh_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// One sensor part as an SPI slave, mode 11
module dsh_dev_part #(
    parameter bit         ACCEL = 1'b0,
    parameter logic [7:0] SEED  = 8'h00
) (
    // Serial pins and mode enable
    input  wire logic sck,
    input  wire logic mosi,
    input  wire logic cs_n,
    input  wire logic en,
    output logic      sdo
);
    logic [7:0] mem [128];
    logic [7:0] rx, sh;
    logic [6:0] ptr;
    logic       rd, bit_q;
    int         cnt;
    // Fixed pattern so the bench can predict contents
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = SEED ^ 8'(i);
        bit_q = 1'b0;
        cnt = 0;
    end
    always @(negedge cs_n) cnt = 0;
    // Sample on the rise: direction, address, then data
    always @(posedge sck) if (!cs_n && en) begin
        rx = {rx[6:0], mosi};
        cnt++;
        if (cnt == 8) {rd, ptr} = rx;
        if (cnt == 16 && !rd) mem[ptr] = rx;
    end
    // Drive on the fall; the accel part sends a junk byte first
    always @(negedge sck) if (!cs_n && en && rd && cnt >= 8) begin
        if (cnt % 8 == 0) begin
            if (ACCEL && cnt == 8) sh = 8'($urandom);
            else begin
                sh = mem[ptr];
                ptr++;
            end
        end
        bit_q = sh[7 - cnt % 8];
    end
    // Released output shows the inverse, so a stale bit never passes
    assign sdo = (!cs_n && en) ? bit_q : ~bit_q;
endmodule : dsh_dev_part

// ==========================================
// Both parts sharing clock and data-in pins
module dsh_dev_model #(
    parameter logic [7:0] ASEED = 8'h00,
    parameter logic [7:0] GSEED = 8'h00
) (
    // Host side pins
    input  wire logic protocol_select_strap,
    input  wire logic sck,
    input  wire logic mosi,
    input  wire logic accel_chip_select_n,
    input  wire logic gyro_chip_select_n,
    output logic      accel_serial_out,
    output logic      gyro_serial_out
);
    logic accel_spi, seen_low;
    initial accel_spi = 1'b0;
    initial seen_low = 1'b0;
    // Only a real rise after a low level counts, not power-up settling
    always @(negedge accel_chip_select_n) seen_low = 1'b1;
    always @(posedge accel_chip_select_n) if (seen_low) accel_spi = 1'b1;
    dsh_dev_part #(.ACCEL(1'b1), .SEED(ASEED)) acc (.sck(sck), .mosi(mosi),
        .cs_n(accel_chip_select_n), .en(accel_spi),
        .sdo(accel_serial_out));
    // Strap low keeps the gyro part off I2C; its addressing goes unused
    dsh_dev_part #(.ACCEL(1'b0), .SEED(GSEED)) gyr (.sck(sck), .mosi(mosi),
        .cs_n(gyro_chip_select_n), .en(protocol_select_strap === 1'b0),
        .sdo(gyro_serial_out));
endmodule : dsh_dev_model
`default_nettype wire

// File: testbench/dsh_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Self-checking bench for the sensor host
module dsh_host_tb;
    import dsh_pkg::*;
    localparam int ASEED = 8'h5A;
    localparam int GSEED = 8'hC3;
    logic     clk, rst, link_clk, link_rst, req_valid, req_ready, init_done;
    logic     strap, sck, mosi, acs_n, gcs_n, aso, gso;
    dsh_req_t req;
    dsh_rsp_t rsp;
    int       err_count, checked;
    int       aexp [128], gexp [128];
    int       q [$];
    dsh_host dut (.clk(clk), .rst(rst), .link_clk(link_clk),
        .link_rst(link_rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp(rsp), .init_done(init_done),
        .protocol_select_strap(strap), .sck(sck), .mosi(mosi),
        .accel_chip_select_n(acs_n), .gyro_chip_select_n(gcs_n),
        .accel_serial_out(aso), .gyro_serial_out(gso));
    dsh_dev_model #(.ASEED(8'h5A), .GSEED(8'hC3)) dev (
        .protocol_select_strap(strap), .sck(sck), .mosi(mosi),
        .accel_chip_select_n(acs_n), .gyro_chip_select_n(gcs_n),
        .accel_serial_out(aso), .gyro_serial_out(gso));
    // Clocks: link clock offset by 3 ns; its rising edge meets a clk rise every 320 ns
    always #5 clk = ~clk;
    initial begin
        link_clk = 1'b0;
        #3;
        forever #32 link_clk = ~link_clk;
    end
    // Link reset spans its own clock, not only the fast one
    initial begin
        link_rst = 1'b1;
        repeat (4) @(negedge link_clk);
        link_rst = 1'b0;
    end
    // Never both parts selected on a clock edge
    always @(posedge sck) if (!rst) check({31'b0, acs_n | gcs_n}, 1);
    // Clock must idle high when a select falls, so mode 11 is chosen
    always @(negedge acs_n or negedge gcs_n) check({31'b0, sck}, 1);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // One request, then its reads against the model or the write gap
    task automatic xfer(input logic g, input logic r, input logic [6:0] a,
                        input logic [7:0] d, input int nb);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        check({31'b0, req_ready}, 1);
        req = '{part_gyro: g, dir_read: r, addr: a, wdata: d,
                nbytes: 4'(nb), suspend: 1'b0};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        n = 0;
        if (!r) begin
            if (g) gexp[a] = d;
            else aexp[a] = d;
            // Gap is timed from the select rise that ends the frame
            while ((acs_n & gcs_n) === 1'b1 && n < 5000) begin
                @(negedge clk);
                n++;
            end
            while ((acs_n & gcs_n) !== 1'b1 && n < 5000) begin
                @(negedge clk);
                n++;
            end
            n = 0;
            while (req_ready !== 1'b1 && n < 5000) begin
                @(negedge clk);
                n++;
            end
            check({31'b0, n >= WAIT_NORMAL_CYC}, 1);
        end else begin
            for (int i = 0; i < nb; i++)
                q.push_back(g ? gexp[(a + i) % 128] : aexp[(a + i) % 128]);
            for (int i = 0; i < nb; i++) begin
                while (rsp.valid !== 1'b1 && n < 9000) begin
                    @(negedge clk);
                    n++;
                end
                check({31'b0, rsp.valid}, 1);
                check({24'b0, rsp.data}, 32'(q.pop_front()));
                check({31'b0, rsp.last}, {31'b0, i == nb - 1});
                @(negedge clk);
            end
        end
    endtask : xfer
    // Main sequence
    initial begin
        int n;
        clk = 1'b0;
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        err_count = 0;
        checked = 0;
        void'($urandom(34476));
        for (int i = 0; i < 128; i++) begin
            aexp[i] = ASEED ^ i;
            gexp[i] = GSEED ^ i;
        end
        repeat (4) @(negedge clk);
        rst = 1'b0;
        n = 0;
        while (init_done !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        check({31'b0, init_done}, 1);
        check({31'b0, dev.accel_spi}, 1);
        check({31'b0, strap}, 0);
        xfer(1'b0, 1'b1, ACCEL_DATA_ADDR, 8'h00, 6);
        xfer(1'b1, 1'b0, 7'h10, 8'hE7, 0);
        xfer(1'b1, 1'b1, 7'h0F, 8'h00, 3);
        xfer(1'b0, 1'b0, 7'h20, 8'h81, 0);
        xfer(1'b0, 1'b1, 7'h20, 8'h00, 1);
        for (int k = 0; k < 8; k++)
            xfer(1'($urandom), 1'($urandom), 7'($urandom % 100),
                 8'($urandom), 1 + $urandom % 6);
        give_verdict();
    end
    // Watchdog well past the expected few tens of microseconds
    initial begin
        #900us;
        err_count++;
        give_verdict();
    end
endmodule : dsh_host_tb
`default_nettype wire
